// ===== bench/eth_ports.sv
// ethernet port side model: hands one frame header per send call
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
`include "vlan_defines.vh"
module eth_ports (
  input  wire               clk,
  output reg                frm_valid,
  output reg [`PORT_W-1:0]  frm_port,
  output reg                frm_tagged,
  output reg [`VID_W-1:0]   frm_vid
);
  initial {frm_valid, frm_port, frm_tagged, frm_vid} = 0;
  // header stands one cycle; idle fields are inverted, never held
  task send(input [`PORT_W-1:0] p, input t, input [`VID_W-1:0] v);
    begin
      @(posedge clk);
      {frm_valid, frm_port, frm_tagged, frm_vid} <= {1'b1, p, t, v};
      @(posedge clk);
      {frm_valid, frm_port, frm_tagged, frm_vid} <= {1'b0, ~p, ~t, ~v};
    end
  endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for vlan ingress classification and masks
// assumes eth_ports and the bound monitor are compiled before it
`timescale 1ns/1ps
`include "vlan_defines.vh"
module testbench;
  reg clk, rstn, port_cfg_we, cfg_aware, cfg_filter, cfg_tagged_only;
  reg [2:0] port_cfg_sel;
  reg [11:0] cfg_port_default_vlan_id, cfg_untagged_egress_vlan_id;
  reg [11:0] vlan_vid;
  reg [1:0] cfg_egress_mode, pvlan_idx;
  reg vlan_we, vlan_valid, pvlan_create, pvlan_delete, pvlan_we, iso_we;
  reg [3:0] vlan_idx;
  reg [7:0] vlan_members, pvlan_members, iso_mask;
  wire frm_valid, frm_tagged, res_valid, res_drop, res_strip;
  wire [2:0] frm_port;
  wire [11:0] frm_vid, res_vid;
  wire [7:0] res_dest, res_untag, iso_status;
  integer n_fail = 0, cmp_count = 0;
  eth_ports i_eth (.clk, .frm_valid, .frm_port, .frm_tagged, .frm_vid);
  vlan_ingress i_dut (.clk, .rstn, .port_cfg_we, .port_cfg_sel,
    .cfg_aware, .cfg_filter, .cfg_tagged_only, .cfg_port_default_vlan_id,
    .cfg_untagged_egress_vlan_id,
    .cfg_egress_mode, .vlan_we, .vlan_idx, .vlan_vid, .vlan_valid,
    .vlan_members, .pvlan_create, .pvlan_delete, .pvlan_we, .pvlan_idx,
    .pvlan_members, .iso_we, .iso_mask, .frm_valid, .frm_port,
    .frm_tagged, .frm_vid, .res_valid, .res_drop, .res_vid, .res_strip,
    .res_dest, .res_untag, .iso_status);
  always #4 clk = ~clk;
  task conclude;
    begin
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task cmp(input [30:0] got, input [30:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one header, then valid, drop, vid, strip, dest and untag at once
  task fr(input [2:0] p, input t, input [11:0] v, input [30:0] e);
    begin
      i_eth.send(p, t, v);
      #1 cmp({res_valid, res_drop, res_vid, res_strip, res_dest,
              res_untag}, e);
    end
  endtask
  task pc(input [2:0] p, input a, f, t, input [11:0] pv, uv,
          input [1:0] m);
    begin
      @(posedge clk);
      {port_cfg_we, port_cfg_sel, cfg_aware, cfg_filter} <= {1'b1, p, a, f};
      {cfg_tagged_only, cfg_port_default_vlan_id} <= {t, pv};
      {cfg_untagged_egress_vlan_id, cfg_egress_mode} <= {uv, m};
      @(posedge clk);
      port_cfg_we <= 1'b0;
    end
  endtask
  task pv(input [2:0] op, input [1:0] i, input [7:0] m);
    begin
      @(posedge clk);
      {pvlan_create, pvlan_delete, pvlan_we, pvlan_idx} <= {op, i};
      pvlan_members <= m;
      @(posedge clk);
      {pvlan_create, pvlan_delete, pvlan_we} <= 3'h0;
    end
  endtask
  task iw(input [7:0] m);
    begin
      @(posedge clk);
      {iso_we, iso_mask} <= {1'b1, m};
      @(posedge clk);
      iso_we <= 1'b0;
      // the status output trails the isolation bits by one edge
      @(posedge clk);
      #1 cmp({23'h0, iso_status}, {23'h0, m});
    end
  endtask
  task t_defaults;
    begin
      @(posedge clk);
      #1 cmp({23'h0, iso_status}, 31'h0);
      fr(3'h2, 1'b0, 12'h000, {2'h2, 12'h001, 1'h0, 8'hfb, 8'hff});
      fr(3'h2, 1'b1, 12'h005, {2'h2, 12'h001, 1'h0, 8'hfb, 8'hff});
    end
  endtask
  task t_aware;
    begin
      pc(3'h6, 1'b0, 1'b0, 1'b0, 12'h001, 12'h001, 2'h2);
      pc(3'h7, 1'b0, 1'b0, 1'b0, 12'h001, 12'h001, 2'h1);
      pc(3'h1, 1'b1, 1'b0, 1'b0, 12'h001, 12'h005, 2'h0);
      @(posedge clk);
      {vlan_we, vlan_idx, vlan_vid, vlan_members} <= {5'h11, 12'h005, 8'h0f};
      @(posedge clk);
      vlan_we <= 1'b0;
      fr(3'h1, 1'b1, 12'h005, {2'h2, 12'h005, 1'h1, 8'h0d, 8'h42});
      fr(3'h0, 1'b0, 12'h000, {2'h2, 12'h001, 1'h0, 8'hfe, 8'h7d});
      fr(3'h1, 1'b1, 12'h009, {2'h3, 12'h009, 1'h1, 8'h00, 8'h40});
    end
  endtask
  task t_filter;
    begin
      pc(3'h4, 1'b1, 1'b1, 1'b0, 12'h001, 12'h001, 2'h0);
      fr(3'h4, 1'b1, 12'h005, {2'h3, 12'h005, 1'h1, 8'h00, 8'h42});
      fr(3'h4, 1'b0, 12'h000, {2'h2, 12'h001, 1'h0, 8'hef, 8'h7d});
      pc(3'h3, 1'b0, 1'b0, 1'b1, 12'h001, 12'h001, 2'h0);
      fr(3'h3, 1'b0, 12'h000, {2'h3, 12'h001, 1'h0, 8'h00, 8'h7d});
      fr(3'h3, 1'b1, 12'h005, {2'h2, 12'h001, 1'h0, 8'hf7, 8'h7d});
    end
  endtask
  task t_pvlan;
    begin
      pv(3'h4, 2'h1, 8'hff);
      pv(3'h1, 2'h0, 8'h3c);
      iw(8'h30);
      fr(3'h4, 1'b0, 12'h000, {2'h2, 12'h001, 1'h0, 8'h0c, 8'h7d});
      fr(3'h2, 1'b0, 12'h000, {2'h2, 12'h001, 1'h0, 8'hfb, 8'h7d});
      fr(3'h0, 1'b0, 12'h000, {2'h3, 12'h001, 1'h0, 8'h00, 8'h7d});
      pv(3'h1, 2'h1, 8'h01);
      fr(3'h0, 1'b0, 12'h000, {2'h2, 12'h001, 1'h0, 8'hfe, 8'h7d});
      pv(3'h2, 2'h1, 8'h00);
      fr(3'h0, 1'b0, 12'h000, {2'h3, 12'h001, 1'h0, 8'h00, 8'h7d});
      iw(8'h00);
    end
  endtask
  initial begin
    {clk, rstn, port_cfg_we, port_cfg_sel, cfg_aware, cfg_filter} = 0;
    {cfg_tagged_only, cfg_port_default_vlan_id} = 0;
    {cfg_untagged_egress_vlan_id, cfg_egress_mode} = 0;
    {vlan_we, vlan_idx, vlan_vid, vlan_valid, vlan_members} = 0;
    {pvlan_create, pvlan_delete, pvlan_we, pvlan_idx, pvlan_members} = 0;
    {iso_we, iso_mask} = 0;
    vlan_valid = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_defaults;
    t_aware;
    t_filter;
    t_pvlan;
    conclude;
  end
  // cut a hang short well beyond the few dozen cycles of the run
  initial begin
    #20000;
    n_fail = n_fail + 1;
    conclude;
  end
endmodule

// ===== bench/vlan_ingress_monitor.sv
// checker for result timing, masks and isolation of vlan_ingress
// assumes one clock and the async active-low reset of the design
`timescale 1ns/1ps
`include "vlan_defines.vh"
module vlan_ingress_monitor (
  input wire               clk,
  input wire               rstn,
  input wire               frm_valid,
  input wire [`PORT_W-1:0] frm_port,
  input wire               frm_tagged,
  input wire               iso_we,
  input wire [`NPORTS-1:0] iso_mask,
  input wire               res_valid,
  input wire               res_drop,
  input wire               res_strip,
  input wire [`NPORTS-1:0] res_dest,
  input wire [`NPORTS-1:0] iso_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  reg [`PORT_W-1:0] src_r;  // source port of the result now shown
  // track the frame in flight so results can be tied to it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_r <= {`PORT_W{1'b0}};
    end else begin
      src_r <= frm_port;
    end
  end
  sequence s_untag;
    frm_valid && !frm_tagged;
  endsequence
  property p_take; frm_valid |=> res_valid; endproperty
  a_take: assert property (p_take) else $error("no result");
  property p_idle; !frm_valid |=> !res_valid; endproperty
  a_idle: assert property (p_idle) else $error("spurious result");
  property p_drop; res_drop |-> res_dest == 0; endproperty
  a_drop: assert property (p_drop) else $error("dropped but sent");
  property p_self; res_valid |-> !res_dest[src_r]; endproperty
  a_self: assert property (p_self) else $error("sent to source");
  property p_strip; s_untag |=> !res_strip; endproperty
  a_strip: assert property (p_strip) else $error("untagged stripped");
  // isolation bits land one edge after the strobe, the status one more
  property p_iso_set;
    iso_we |=> ##1 iso_status == $past(iso_mask, 2);
  endproperty
  a_iso_set: assert property (p_iso_set) else $error("iso not set");
  property p_iso_hold;
    !iso_we && !$past(iso_we) |=> $stable(iso_status);
  endproperty
  a_iso_hold: assert property (p_iso_hold) else $error("iso moved");
  property p_iso_dest;
    res_valid && iso_status[src_r] |-> (res_dest & iso_status) == 0;
  endproperty
  a_iso_dest: assert property (p_iso_dest) else $error("iso leak");
endmodule
bind vlan_ingress vlan_ingress_monitor i_mon (.clk, .rstn, .frm_valid,
  .frm_port, .frm_tagged, .iso_we, .iso_mask, .res_valid, .res_drop,
  .res_strip, .res_dest, .iso_status);

// ===== common/vlan_defines.vh
// constants for the vlan ingress and private vlan mask block
// assumes one switch core clock and a small fixed port count
// How it works
// - aware ports strip tag from tagged frames
// - aware ports classify tagged frames by tag
// - unaware ports use default vid, keep tag
// - ingress filter drops non-member classified vlan
// - tagged-only ports drop untagged frames
// - each port holds an untagged egress vid
// - private vlan is per-source-port mask, id-free
// - forward only if in vlan and pvlan
// - reset: unaware, vlan 1, pvlan 1
// - unaware port one vlan, many pvlans
// - new pvlan entry starts with empty mask
// - promiscuous port talks to all pvlan ports
// - isolated port talks only to promiscuous ports
// - isolation is one global bit per port
// - promiscuous source uses vlan mask only
// - isolated source also applies pvlan mask
// - isolation bits cleared at reset
// - untag-port-vlan egress untags the port's untagged egress vid only
`ifndef VLAN_DEFINES_VH
`define VLAN_DEFINES_VH
`define NPORTS       8
`define PORT_W       3
`define VID_W        12
`define NVLAN        16
`define VIDX_W       4
`define NPVLAN       4
`define PVIDX_W      2
`define VID_RESET    12'h001
`define EG_UNTAG_DEFAULT 2'h0
`define EG_TAG_ALL    2'h1
`define EG_UNTAG_ALL  2'h2
`endif

// ===== core/vlan_classify.v
// per-frame ingress classification: vid choice, strip, accept
// assumes frame header fields are stable while valid is high
`timescale 1ns/1ps
`include "vlan_defines.vh"
module vlan_classify (
  input  wire               aware,        // port is vlan aware
  input  wire               tagged_only,  // port accepts tagged only
  input  wire               is_tagged,    // frame carries a tag
  input  wire [`VID_W-1:0]  tag_vid,      // vid inside the tag
  input  wire [`VID_W-1:0]  port_default_vlan_id,  // port default vid
  output reg  [`VID_W-1:0]  class_vid,    // classified vid
  output reg                strip,        // remove tag on ingress
  output reg                type_drop     // frame type refused
);
  // classification decision
  always @* begin
    if (aware && is_tagged) begin
      class_vid = tag_vid;
      strip     = 1'b1;
    end else begin
      class_vid = port_default_vlan_id;
      strip     = 1'b0;
    end
    type_drop = tagged_only & ~is_tagged;
  end
endmodule

// ===== core/vlan_ingress.v
// vlan ingress classification and private vlan forwarding mask
// assumes config writes are single-cycle strobes, one frame per cycle
`timescale 1ns/1ps
`include "vlan_defines.vh"
module vlan_ingress (
  input  wire                clk,
  input  wire                rstn,
  // per-port configuration write
  input  wire                port_cfg_we,      // write port config
  input  wire [`PORT_W-1:0]  port_cfg_sel,     // port to write
  input  wire                cfg_aware,        // vlan awareness
  input  wire                cfg_filter,       // ingress filtering
  input  wire                cfg_tagged_only,  // accept tagged only
  input  wire [`VID_W-1:0]   cfg_port_default_vlan_id,     // default vid
  input  wire [`VID_W-1:0]   cfg_untagged_egress_vlan_id,  // egress vid
  input  wire [1:0]          cfg_egress_mode,  // egress tagging mode
  // vlan table write
  input  wire                vlan_we,          // write vlan entry
  input  wire [`VIDX_W-1:0]  vlan_idx,         // entry index
  input  wire [`VID_W-1:0]   vlan_vid,         // entry vid
  input  wire                vlan_valid,       // entry in use
  input  wire [`NPORTS-1:0]  vlan_members,     // member ports
  // private vlan table write
  input  wire                pvlan_create,     // new entry, empty mask
  input  wire                pvlan_delete,     // delete entry
  input  wire                pvlan_we,         // write member mask
  input  wire [`PVIDX_W-1:0] pvlan_idx,        // entry index
  input  wire [`NPORTS-1:0]  pvlan_members,    // member ports
  // isolation write
  input  wire                iso_we,           // write isolation mask
  input  wire [`NPORTS-1:0]  iso_mask,         // isolated ports
  // frame header in
  input  wire                frm_valid,        // header valid
  input  wire [`PORT_W-1:0]  frm_port,         // ingress port
  input  wire                frm_tagged,       // header carries tag
  input  wire [`VID_W-1:0]   frm_vid,          // tag vid
  // result out, one cycle later
  output reg                 res_valid,        // result valid pulse
  output reg                 res_drop,         // frame discarded
  output reg  [`VID_W-1:0]   res_vid,          // classified vid
  output reg                 res_strip,        // strip tag on ingress
  output reg  [`NPORTS-1:0]  res_dest,         // destination ports
  output reg  [`NPORTS-1:0]  res_untag,        // ports sending untagged
  output reg  [`NPORTS-1:0]  iso_status        // current isolation bits
);
  // per-port config arrays
  reg               aware_r   [0:`NPORTS-1];  // awareness
  reg               filter_r  [0:`NPORTS-1];  // ingress filtering
  reg               tonly_r   [0:`NPORTS-1];  // tagged-only accept
  reg [`VID_W-1:0]  port_default_vlan_id_r    [0:`NPORTS-1];  // default
  reg [`VID_W-1:0]  untagged_egress_vlan_id_r [0:`NPORTS-1];  // egress
  reg [1:0]         egmode_r  [0:`NPORTS-1];  // egress mode
  // vlan table
  reg [`VID_W-1:0]  vt_vid_r  [0:`NVLAN-1];   // entry vid
  reg               vt_val_r  [0:`NVLAN-1];   // entry valid
  reg [`NPORTS-1:0] vt_mem_r  [0:`NVLAN-1];   // entry members
  // private vlan table
  reg               pv_val_r  [0:`NPVLAN-1];  // entry valid
  reg [`NPORTS-1:0] pv_mem_r  [0:`NPVLAN-1];  // entry members
  reg [`NPORTS-1:0] iso_r;                    // isolation bits
  integer i;

  // classification of the current header
  wire              aware_cur  = aware_r[frm_port];
  wire [`VID_W-1:0] class_vid;
  wire              strip;
  wire              type_drop;

  vlan_classify u_classify (
    .aware       (aware_cur),
    .tagged_only (tonly_r[frm_port]),
    .is_tagged   (frm_tagged),
    .tag_vid     (frm_vid),
    .port_default_vlan_id (port_default_vlan_id_r[frm_port]),
    .class_vid   (class_vid),
    .strip       (strip),
    .type_drop   (type_drop)
  );

  // one-hot of a port number
  function [`NPORTS-1:0] onehot;
    input [`PORT_W-1:0] p;
    begin
      onehot = {{(`NPORTS-1){1'b0}}, 1'b1} << p;
    end
  endfunction

  // vlan table lookup and pvlan union for source port
  reg [`NPORTS-1:0] vmask;      // members of classified vlan
  reg               vhit;       // classified vlan exists
  reg [`NPORTS-1:0] pvmask;     // union of pvlans holding source
  reg               in_pvlan;   // source in some pvlan
  reg               in_vlan;    // source in some vlan
  reg [`NPORTS-1:0] src;        // source one-hot
  reg [`NPORTS-1:0] dest;       // computed destinations
  reg [`NPORTS-1:0] untag;      // untagged egress ports
  reg               drop;       // discard decision
  integer k;
  always @* begin
    src      = onehot(frm_port);
    vmask    = {`NPORTS{1'b0}};
    vhit     = 1'b0;
    pvmask   = {`NPORTS{1'b0}};
    in_pvlan = 1'b0;
    in_vlan  = 1'b0;
    untag    = {`NPORTS{1'b0}};
    for (k = 0; k < `NVLAN; k = k + 1) begin
      if (vt_val_r[k] && vt_vid_r[k] == class_vid) begin
        vmask = vmask | vt_mem_r[k];
        vhit  = 1'b1;
      end
      if (vt_val_r[k] && (vt_mem_r[k] & src) != {`NPORTS{1'b0}})
        in_vlan = 1'b1;
    end
    // pvlan membership is by source port, not by vid
    for (k = 0; k < `NPVLAN; k = k + 1) begin
      if (pv_val_r[k] && (pv_mem_r[k] & src) != {`NPORTS{1'b0}}) begin
        pvmask   = pvmask | pv_mem_r[k];
        in_pvlan = 1'b1;
      end
    end
    // promiscuous source: vlan mask only
    // isolated source: pvlan mask and promiscuous only
    if (iso_r[frm_port])
      dest = vmask & pvmask & ~iso_r;
    else
      dest = vmask;
    dest = dest & ~src;
    // must be in a vlan and a pvlan to forward
    drop = type_drop | ~in_vlan | ~in_pvlan | ~vhit;
    if (filter_r[frm_port] && (vmask & src) == {`NPORTS{1'b0}})
      drop = 1'b1;
    // egress tagging per destination port
    for (k = 0; k < `NPORTS; k = k + 1) begin
      case (egmode_r[k])
        `EG_UNTAG_DEFAULT:
          untag[k] = (class_vid == untagged_egress_vlan_id_r[k]);
        `EG_UNTAG_ALL:  untag[k] = 1'b1;
        default:        untag[k] = 1'b0;
      endcase
    end
  end

  // configuration storage and reset defaults
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `NPORTS; i = i + 1) begin
        aware_r[i]  <= 1'b0;
        filter_r[i] <= 1'b0;
        tonly_r[i]  <= 1'b0;
        port_default_vlan_id_r[i]    <= `VID_RESET;
        untagged_egress_vlan_id_r[i] <= `VID_RESET;
        egmode_r[i] <= `EG_UNTAG_DEFAULT;
      end
      for (i = 0; i < `NVLAN; i = i + 1) begin
        vt_vid_r[i] <= `VID_RESET;
        vt_val_r[i] <= (i == 0);             // vlan 1 holds all
        vt_mem_r[i] <= (i == 0) ? {`NPORTS{1'b1}} : {`NPORTS{1'b0}};
      end
      for (i = 0; i < `NPVLAN; i = i + 1) begin
        pv_val_r[i] <= (i == 0);             // pvlan 1 holds all
        pv_mem_r[i] <= (i == 0) ? {`NPORTS{1'b1}} : {`NPORTS{1'b0}};
      end
      iso_r <= {`NPORTS{1'b0}};
    end else begin
      // port config write
      if (port_cfg_we) begin
        aware_r[port_cfg_sel]  <= cfg_aware;
        filter_r[port_cfg_sel] <= cfg_filter;
        tonly_r[port_cfg_sel]  <= cfg_tagged_only;
        port_default_vlan_id_r[port_cfg_sel] <= cfg_port_default_vlan_id;
        untagged_egress_vlan_id_r[port_cfg_sel] <=
          cfg_untagged_egress_vlan_id;
        egmode_r[port_cfg_sel] <= cfg_egress_mode;
      end
      // vlan table write
      if (vlan_we) begin
        vt_vid_r[vlan_idx] <= vlan_vid;
        vt_val_r[vlan_idx] <= vlan_valid;
        vt_mem_r[vlan_idx] <= vlan_members;
      end
      // pvlan create, delete, member write; create clears mask
      if (pvlan_create) begin
        pv_val_r[pvlan_idx] <= 1'b1;
        pv_mem_r[pvlan_idx] <= {`NPORTS{1'b0}};
      end else if (pvlan_delete) begin
        pv_val_r[pvlan_idx] <= 1'b0;
        pv_mem_r[pvlan_idx] <= {`NPORTS{1'b0}};
      end else if (pvlan_we) begin
        pv_mem_r[pvlan_idx] <= pvlan_members;
      end
      // one global isolation bit per port
      if (iso_we)
        iso_r <= iso_mask;
    end
  end

  // registered result
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_valid  <= 1'b0;
      res_drop   <= 1'b0;
      res_vid    <= {`VID_W{1'b0}};
      res_strip  <= 1'b0;
      res_dest   <= {`NPORTS{1'b0}};
      res_untag  <= {`NPORTS{1'b0}};
      iso_status <= {`NPORTS{1'b0}};
    end else begin
      res_valid  <= frm_valid;
      res_drop   <= frm_valid & drop;
      res_vid    <= class_vid;
      res_strip  <= frm_valid & strip;
      res_dest   <= (frm_valid & ~drop) ? dest : {`NPORTS{1'b0}};
      res_untag  <= untag;
      iso_status <= iso_r;
    end
  end
endmodule
